// ===== fhp_pkg.sv
// Shared constants and types of the floppy host port
package fhp_pkg;

  // ********************************************
  // Register select and status layout
  // ********************************************
  localparam logic FHP_SEL_STATUS  = 1'b0;
  localparam logic FHP_SEL_DATA    = 1'b1;
  localparam int   FHP_ST_SEEK_LSB = 0;
  localparam int   FHP_ST_CB       = 4;
  localparam int   FHP_ST_NDM      = 5;
  localparam int   FHP_ST_DIO      = 6;
  localparam int   FHP_ST_RQM      = 7;
  localparam int   FHP_DRIVES      = 4;
  localparam int   FHP_BYTE_W      = 8;
  localparam int   FHP_BUF_DEPTH   = 2;

  // ********************************************
  // Reset values
  // ********************************************
  localparam logic       FHP_PIN_RST  = 1'b0;
  localparam logic [7:0] FHP_BYTE_RST = 8'h00;

  // ********************************************
  // Timing
  // ********************************************
  localparam int FHP_CLK_PERIOD_NS    = 50;
  localparam int FHP_RQM_DELAY_NS     = 12000;
  localparam int FHP_RQM_DELAY_CYCLES =
    (FHP_RQM_DELAY_NS + FHP_CLK_PERIOD_NS - 1) / FHP_CLK_PERIOD_NS;

  // ********************************************
  // Command phase
  // ********************************************
  typedef enum logic [1:0] {
    FHP_PH_IDLE   = 2'b00,
    FHP_PH_EXEC   = 2'b01,
    FHP_PH_RESULT = 2'b11
  } fhp_phase_e;

endpackage : fhp_pkg

// ===== fhp_pair_buffer.sv
// Small valid/ready byte buffer
`timescale 1ns/1ns
module fhp_pair_buffer
  import fhp_pkg::*;
#(
  parameter int WIDTH = FHP_BYTE_W,
  parameter int DEPTH = FHP_BUF_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW:0]      count;
  logic [PW:0]      next_count;
  logic             do_push;
  logic             do_pop;

  assign do_push  = in_valid & in_ready;
  assign do_pop   = out_valid & out_ready;
  assign out_data = mem[rptr];

  always_comb begin
    next_count = count;
    if (do_push & ~do_pop) begin
      next_count = count + 1'b1;
    end else if (~do_push & do_pop) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (do_push) begin
        wptr <= (wptr == LAST) ? '0 : wptr + 1'b1;
      end
      if (do_pop) begin
        rptr <= (rptr == LAST) ? '0 : rptr + 1'b1;
      end
    end
  end

  // Flags kept in flops so ready and valid leave without logic
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      in_ready  <= (next_count != FULL);
      out_valid <= (next_count != '0);
    end
  end
endmodule : fhp_pair_buffer

// ===== fhp_rqm_timer.sv
// Hold-off timer for the master request flag
`timescale 1ns/1ns
module fhp_rqm_timer
  import fhp_pkg::*;
#(
  parameter int CYCLES = FHP_RQM_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= CW'(CYCLES);
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign busy = (cnt != '0);
endmodule : fhp_rqm_timer

// ===== fhp_host_port.sv
// Processor and DMA port, main status and drive pins of the floppy controller
`timescale 1ns/1ns

// How it works
// - Reset idles, drive outputs low.
// - Select ignored while chip deselected; strobes also, unless acknowledge low.
// - Select low status, select high data.
// - Read strobe drives status or data byte.
// - Write strobe with select high loads data.
// - Status register is read-only, readable unless acknowledge low.
// - Request DMA when byte needed; acknowledge low.
// - Terminal count ends execution and transfer.
// - Non-DMA execution interrupts on every byte.
// - Mode pin high seeking, low read/write.
// - Shared outputs: current/fault reset or direction/step.
// - Shared inputs read by mode.
// - Head select high head one.
// - Density pin high for double density.
// - Loop oscillator pin low inhibits.
// - Status bits 0-3 show drives seeking.
// - Status bit 4 shows read/write busy.
// - Status bit 5 only in non-DMA execution.
// - Status bit 6 gives transfer direction.
// - Status bit 7 ready to exchange byte.
// - Ready flag held off after each exchange.
// - DMA request drops when acknowledge low.
module fhp_host_port
  import fhp_pkg::*;
#(
  parameter int RQM_DELAY_CYCLES = FHP_RQM_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Processor bus
  input  wire logic                  cs_n,
  input  wire logic                  rd_n,
  input  wire logic                  wr_n,
  input  wire logic                  register_select,
  input  wire logic [7:0]            db_in,
  output logic      [7:0]            db_out,
  output logic                       db_oe,
  output logic                       int_req,
  // DMA handshake
  output logic                       dma_request,
  input  wire logic                  dma_acknowledge_n,
  input  wire logic                  terminal_count,
  // Drive and loop pins
  output logic                       seek_mode,
  output logic                       low_current_or_direction,
  output logic                       fault_reset_or_step,
  output logic                       head_select,
  output logic                       double_density,
  output logic                       vco_enable,
  input  wire logic                  protect_or_two_side,
  input  wire logic                  fault_or_track_zero,
  // Controller core: state and drive requests
  input  wire logic [FHP_DRIVES-1:0] drive_seeking_bits,
  input  wire logic                  controller_busy,
  input  wire logic                  core_dma_mode,
  input  wire logic                  core_exec_start,
  input  wire logic                  core_to_host,
  input  wire logic                  core_seek,
  input  wire logic                  core_step_dir,
  input  wire logic                  core_step,
  input  wire logic                  core_low_current,
  input  wire logic                  core_fault_reset,
  input  wire logic                  core_head,
  input  wire logic                  core_double_density,
  input  wire logic                  core_vco_enable,
  // Controller core: bytes to the processor
  input  wire logic                  core_res_valid,
  output logic                       core_res_ready,
  input  wire logic [7:0]            core_res_data,
  // Controller core: bytes from the processor
  output logic                       core_cmd_valid,
  input  wire logic                  core_cmd_ready,
  output logic      [7:0]            core_cmd_data,
  // Controller core: events and sensed drive state
  output logic                       core_exec_end,
  output logic                       core_write_protect,
  output logic                       core_drive_fault,
  output logic                       core_two_sided,
  output logic                       core_track_zero
);

  // ********************************************
  // Access decode
  // ********************************************
  fhp_phase_e  phase;
  logic        sel;
  logic        data_path;
  logic        rd_act;
  logic        wr_act;
  logic        prev_rd;
  logic        prev_wr;
  logic        rd_start;
  logic        wr_start;
  logic        push;
  logic        pop;
  logic        xfer;
  logic [7:0]  status;
  logic        rqm;
  logic        next_rqm;
  logic        non_dma_execution;
  logic        tmr_busy;
  logic        up_valid;
  logic [7:0]  up_data;
  logic        down_ready;
  logic        tc_end;
  logic        ph_exec;

  assign sel       = ~cs_n;
  // Acknowledge selects the data register on its own during DMA
  assign data_path = (sel & (register_select == FHP_SEL_DATA)) | ~dma_acknowledge_n;
  // Both-low or status-write combinations match neither term
  assign rd_act    = ~rd_n & wr_n & (sel | ~dma_acknowledge_n);
  assign wr_act    = ~wr_n & rd_n & data_path;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_rd <= 1'b0;
      prev_wr <= 1'b0;
    end else begin
      prev_rd <= rd_act;
      prev_wr <= wr_act;
    end
  end

  assign rd_start = rd_act & ~prev_rd;
  assign wr_start = wr_act & ~prev_wr;
  // A write into a full stack is dropped; the host should wait for ready
  assign push     = wr_start & down_ready;
  assign pop      = rd_start & data_path & up_valid;
  assign xfer     = push | pop;

  // ********************************************
  // Data stack in both directions
  // ********************************************
  fhp_pair_buffer #(.WIDTH(FHP_BYTE_W), .DEPTH(FHP_BUF_DEPTH)) u_down (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (down_ready),
    .in_data   (db_in),
    .out_valid (core_cmd_valid),
    .out_ready (core_cmd_ready),
    .out_data  (core_cmd_data)
  );

  fhp_pair_buffer #(.WIDTH(FHP_BYTE_W), .DEPTH(FHP_BUF_DEPTH)) u_up (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (core_res_valid),
    .in_ready  (core_res_ready),
    .in_data   (core_res_data),
    .out_valid (up_valid),
    .out_ready (pop),
    .out_data  (up_data)
  );

  // ********************************************
  // Master request and status
  // ********************************************
  fhp_rqm_timer #(.CYCLES(RQM_DELAY_CYCLES)) u_rqm_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (xfer),
    .busy    (tmr_busy)
  );

  // Ready drops on the exchange itself, then waits out the timer
  assign next_rqm = (core_to_host ? up_valid : down_ready) & ~tmr_busy & ~xfer;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rqm <= 1'b0;
    end else begin
      rqm <= next_rqm;
    end
  end

  assign ph_exec = (phase == FHP_PH_EXEC);
  assign non_dma_execution     = ph_exec & ~core_dma_mode;

  always_comb begin
    status                                           = FHP_BYTE_RST;
    status[FHP_ST_SEEK_LSB +: FHP_DRIVES]            = drive_seeking_bits;
    status[FHP_ST_CB]                                = controller_busy;
    status[FHP_ST_NDM]                               = non_dma_execution;
    status[FHP_ST_DIO]                               = core_to_host;
    status[FHP_ST_RQM]                               = rqm;
  end

  // ********************************************
  // Read data path
  // ********************************************
  // Data byte is latched at the strobe start; status follows live
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      db_out <= FHP_BYTE_RST;
      db_oe  <= 1'b0;
    end else begin
      db_oe <= rd_act;
      if (rd_start & data_path) begin
        db_out <= up_data;
      end else if (rd_act & ~data_path) begin
        db_out <= status;
      end
    end
  end

  // ********************************************
  // Command phase tracking
  // ********************************************
  assign tc_end = ph_exec & terminal_count;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= FHP_PH_IDLE;
    end else begin
      case (phase)
        FHP_PH_IDLE: begin
          if (core_exec_start) begin
            phase <= FHP_PH_EXEC;
          end
        end
        FHP_PH_EXEC: begin
          if (terminal_count) begin
            phase <= FHP_PH_RESULT;
          end
        end
        FHP_PH_RESULT: begin
          if (core_exec_start) begin
            phase <= FHP_PH_EXEC;
          end else if (~core_to_host & ~up_valid) begin
            phase <= FHP_PH_IDLE;
          end
        end
        default: begin
          phase <= FHP_PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_exec_end <= 1'b0;
    end else begin
      core_exec_end <= tc_end;
    end
  end

  // ********************************************
  // DMA request and interrupt
  // ********************************************
  // Terminal count blocks a further request in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dma_request <= 1'b0;
    end else begin
      dma_request <= ph_exec & core_dma_mode & next_rqm
                     & dma_acknowledge_n & ~terminal_count;
    end
  end

  // Set beats clear so a byte ready in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_req <= 1'b0;
    end else if ((non_dma_execution & next_rqm & ~rqm) | tc_end) begin
      int_req <= 1'b1;
    end else if ((rd_start | wr_start) & data_path) begin
      int_req <= 1'b0;
    end
  end

  // ********************************************
  // Drive pins
  // ********************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seek_mode                <= FHP_PIN_RST;
      low_current_or_direction <= FHP_PIN_RST;
      fault_reset_or_step      <= FHP_PIN_RST;
      head_select              <= FHP_PIN_RST;
      double_density           <= FHP_PIN_RST;
      vco_enable               <= FHP_PIN_RST;
    end else begin
      seek_mode                <= core_seek;
      low_current_or_direction <= core_seek ? core_step_dir : core_low_current;
      fault_reset_or_step      <= core_seek ? core_step : core_fault_reset;
      head_select              <= core_head;
      double_density           <= core_double_density;
      vco_enable               <= core_vco_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_write_protect <= 1'b0;
      core_drive_fault   <= 1'b0;
      core_two_sided     <= 1'b0;
      core_track_zero    <= 1'b0;
    end else begin
      core_write_protect <= ~seek_mode & protect_or_two_side;
      core_drive_fault   <= ~seek_mode & fault_or_track_zero;
      core_two_sided     <= seek_mode & protect_or_two_side;
      core_track_zero    <= seek_mode & fault_or_track_zero;
    end
  end

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_tc_seen;
    ph_exec && terminal_count;
  endsequence

  sequence s_result_entered;
    (phase == FHP_PH_RESULT) && core_exec_end;
  endsequence

  AST_RESET_OUTS: assert property ($fell(sys_rst) |-> !seek_mode && !head_select
    && !fault_reset_or_step && !vco_enable && phase == FHP_PH_IDLE)
    else $error("drive outputs not low after reset");

  AST_NO_CS: assert property (cs_n && dma_acknowledge_n |=> !db_oe)
    else $error("bus driven while deselected");

  AST_STATUS_READ: assert property (rd_start && !data_path |=> db_out == $past(status))
    else $error("status byte not presented");

  AST_DATA_READ: assert property (pop |=> db_out == $past(up_data))
    else $error("data byte not presented");

  AST_WRITE_TAKEN: assert property (push |=> core_cmd_valid)
    else $error("written byte not stacked");

  AST_ILLEGAL: assert property (!rd_n && !wr_n |-> !push && !pop)
    else $error("illegal strobes moved the stack");

  AST_TC_STOP: assert property (s_tc_seen |=> s_result_entered ##0 !dma_request)
    else $error("terminal count did not end execution");

  AST_DRQ_DROP: assert property (!dma_acknowledge_n |=> !dma_request)
    else $error("request held under acknowledge");

  AST_RQM_DELAY: assert property (xfer |=> !rqm [*8])
    else $error("ready reasserted too early");

  AST_INT_NDM: assert property ($rose(rqm) && $past(non_dma_execution) |-> int_req)
    else $error("no interrupt for non-DMA byte");

  AST_SENSE_MUX: assert property (core_track_zero |-> $past(seek_mode)
    && $past(fault_or_track_zero))
    else $error("track zero sensed outside seek mode");

  AST_NDM_BIT: assert property (ph_exec && !core_dma_mode ##1 !ph_exec
    |-> !status[FHP_ST_NDM])
    else $error("non-DMA bit stayed after execution");

endmodule : fhp_host_port

// ===== fhp_dma_model.sv
// Behavioural DMA controller that answers the host port's transfer requests
`timescale 1ns/1ns
module fhp_dma_model
  import fhp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control from the bench
  input  wire logic       enable,
  input  wire logic [3:0] delay,
  input  wire logic [3:0] n_bytes,
  // Port side
  input  wire logic       dma_request,
  input  wire logic [7:0] db_out,
  output logic            dma_acknowledge_n,
  output logic            rd_n,
  output logic            terminal_count,
  output logic [7:0]      last_byte
);
  logic [1:0] state;
  logic [3:0] wait_c;
  logic [3:0] cnt;

  // ********************************************
  // Transfer sequencing
  // ********************************************
  // Only the read strobe is used, never together with a write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state             <= 2'd0;
      wait_c            <= 4'h0;
      cnt               <= 4'h0;
      dma_acknowledge_n <= 1'b1;
      rd_n              <= 1'b1;
      terminal_count    <= 1'b0;
      last_byte         <= 8'h00;
    end else begin
      terminal_count <= 1'b0;
      case (state)
        2'd0: if (enable && dma_request) begin
          // Slow answer stretches the wait before acknowledging
          if (wait_c == delay) begin
            dma_acknowledge_n <= 1'b0;
            rd_n              <= 1'b0;
            wait_c            <= 4'h0;
            state             <= 2'd1;
          end else begin
            wait_c <= wait_c + 4'h1;
          end
        end
        2'd1: state <= 2'd2;
        2'd2: begin
          last_byte         <= db_out;
          dma_acknowledge_n <= 1'b1;
          rd_n              <= 1'b1;
          cnt               <= cnt + 4'h1;
          terminal_count    <= (cnt + 4'h1 == n_bytes);
          state             <= 2'd3;
        end
        default: state <= 2'd0;
      endcase
    end
  end
endmodule : fhp_dma_model

// ===== test_fhp_host_port.sv
// Self-checking bench of the floppy host port
`timescale 1ns/1ns
module test_fhp_host_port;
  import fhp_pkg::*;
  localparam int DLY = 8;
  logic clk = 0, sys_rst = 1, cs_n = 1, h_rd_n = 1, wr_n = 1, register_select = 0;
  logic [7:0] db_in = 0, db_out, q, core_res_data = 0, core_cmd_data, dma_byte;
  logic db_oe, oe, int_req, dma_request, dma_acknowledge_n_n, p_rd_n, p_tc, h_tc = 0;
  logic seek_mode, lcd, frs, head_select, double_density, vco_enable;
  logic prot = 1, flt = 1, cb = 1, dma_mode = 0, exec_start = 0, to_host = 0, seek = 0;
  logic [3:0] seeking = 4'ha;
  logic res_valid = 0, res_ready, cmd_valid, cmd_ready = 0, exec_end, wprot, dfault, twos, trk0;
  logic dma_en = 0;
  logic [3:0] watch;
  int n_fail = 0, checks = 0;
  logic [7:0] got[$];

  assign watch = {~dma_acknowledge_n_n, dma_request, int_req, exec_end};

  fhp_host_port #(.RQM_DELAY_CYCLES(DLY)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .rd_n(h_rd_n & p_rd_n), .wr_n(wr_n),
    .register_select(register_select), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
    .int_req(int_req), .dma_request(dma_request), .dma_acknowledge_n(dma_acknowledge_n_n),
    .terminal_count(h_tc | p_tc), .seek_mode(seek_mode), .low_current_or_direction(lcd),
    .fault_reset_or_step(frs), .head_select(head_select), .double_density(double_density),
    .vco_enable(vco_enable), .protect_or_two_side(prot), .fault_or_track_zero(flt),
    .drive_seeking_bits(seeking), .controller_busy(cb), .core_dma_mode(dma_mode),
    .core_exec_start(exec_start), .core_to_host(to_host), .core_seek(seek),
    .core_step_dir(1'b1), .core_step(~seek), .core_low_current(1'b0),
    .core_fault_reset(1'b1), .core_head(seek), .core_double_density(seek),
    .core_vco_enable(seek), .core_res_valid(res_valid), .core_res_ready(res_ready),
    .core_res_data(core_res_data), .core_cmd_valid(cmd_valid), .core_cmd_ready(cmd_ready),
    .core_cmd_data(core_cmd_data), .core_exec_end(exec_end), .core_write_protect(wprot),
    .core_drive_fault(dfault), .core_two_sided(twos), .core_track_zero(trk0));

  fhp_dma_model dma_u (
    .clk(clk), .sys_rst(sys_rst), .enable(dma_en), .delay(4'h3), .n_bytes(4'h1),
    .dma_request(dma_request), .db_out(db_out), .dma_acknowledge_n(dma_acknowledge_n_n),
    .rd_n(p_rd_n), .terminal_count(p_tc), .last_byte(dma_byte));

  initial begin
    forever #25 clk = ~clk;
  end

  // ********************************************
  // Access and checking tasks
  // ********************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic cs, input logic a, input logic rd, input logic wr,
                     input logic [7:0] d);
    @(posedge clk);
    cs_n <= cs; register_select <= a; h_rd_n <= rd; wr_n <= wr; db_in <= d;
    @(posedge clk);
    @(posedge clk);
    #1 q = db_out;
    oe = db_oe;
    @(posedge clk);
    cs_n <= 1'b1; h_rd_n <= 1'b1; wr_n <= 1'b1;
  endtask : bus

  function automatic logic [7:0] st(input logic rqm, input logic transfer_direction, input logic non_dma_execution);
    return {rqm, transfer_direction, non_dma_execution, cb, seeking};
  endfunction : st

  task automatic wait_hi(input int idx, input int lim);
    int i;
    i = 0;
    while (watch[idx] !== 1'b1 && i < lim) begin
      @(posedge clk);
      #1 i++;
    end
    check("awaited flag", {7'h0, watch[idx]}, 8'h01);
  endtask : wait_hi

  task automatic push(input logic [7:0] d);
    @(posedge clk);
    res_valid <= 1'b1; core_res_data <= d;
    @(posedge clk);
    res_valid <= 1'b0;
    #1 check("res ready", {7'h0, res_ready}, 8'h01);
  endtask : push

  task automatic pulse_start();
    @(posedge clk); exec_start <= 1'b1;
    @(posedge clk); exec_start <= 1'b0;
  endtask : pulse_start

  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #(50 * 20000);
    n_fail++;
    final_report();
  end

  // ********************************************
  // Scenarios
  // ********************************************
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    #1 check("reset pins", {dma_request, int_req, seek_mode, lcd, frs, head_select,
                            double_density, vco_enable}, 8'h00);
    repeat (DLY + 4) @(posedge clk);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("status", q, st(1'b1, 1'b0, 1'b0));
    check("status oe", {7'h0, oe}, 8'h01);
    bus(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    check("deselected oe", {7'h0, oe}, 8'h00);
    // Stack fill, hold-off, refusals and drain with the core stalled
    seeking <= 4'h5; cb <= 1'b0;
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'ha5);
    check("cmd valid", {cmd_valid, 7'h0}, 8'h80);
    check("cmd data", core_cmd_data, 8'ha5);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("status held off", q, st(1'b0, 1'b0, 1'b0));
    repeat (DLY + 4) @(posedge clk);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("status one free", q, st(1'b1, 1'b0, 1'b0));
    bus(1'b0, 1'b0, 1'b1, 1'b0, 8'h11);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 8'h22);
    bus(1'b1, 1'b1, 1'b1, 1'b0, 8'h33);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h3c);
    repeat (DLY + 4) @(posedge clk);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("status full", q, st(1'b0, 1'b0, 1'b0));
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'hff);
    @(posedge clk); cmd_ready <= 1'b1;
    // Head is taken before the edge that pops it, so no byte slips past
    repeat (6) begin
      #1 if (cmd_valid === 1'b1) got.push_back(core_cmd_data);
      @(posedge clk);
    end
    cmd_ready <= 1'b0;
    check("drained count", 8'(got.size()), 8'h02);
    check("first byte", got[0], 8'ha5);
    check("second byte", got[1], 8'h3c);
    // DMA execution phase ended by terminal count
    dma_mode <= 1'b1; to_host <= 1'b1; dma_en <= 1'b1;
    pulse_start();
    push(8'h3e);
    wait_hi(2, 40);
    wait_hi(3, 20);
    @(posedge clk);
    #1 check("request after ack", {7'h0, dma_request}, 8'h00);
    wait_hi(0, 20);
    check("dma byte", dma_byte, 8'h3e);
    check("int on tc", {7'h0, int_req}, 8'h01);
    dma_en <= 1'b0;
    push(8'hc3);
    repeat (DLY + 4) @(posedge clk);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("result status", q, st(1'b1, 1'b1, 1'b0));
    bus(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
    check("result byte", q, 8'hc3);
    check("int cleared", {7'h0, int_req}, 8'h00);
    to_host <= 1'b0;
    repeat (4) @(posedge clk);
    // Non-DMA execution with an interrupt per byte
    dma_mode <= 1'b0; to_host <= 1'b1;
    pulse_start();
    push(8'h71);
    wait_hi(1, 40);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("exec status", q, st(1'b1, 1'b1, 1'b1));
    bus(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
    check("exec byte", q, 8'h71);
    check("int after read", {7'h0, int_req}, 8'h00);
    @(posedge clk); h_tc <= 1'b1;
    @(posedge clk); h_tc <= 1'b0;
    // End pulse lasts one cycle, launched at this very edge
    #1 check("exec end", {7'h0, exec_end}, 8'h01);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    check("ndm cleared", q, st(1'b0, 1'b1, 1'b0));
    to_host <= 1'b0;
    // Shared drive pins in both modes
    for (int m = 0; m < 2; m++) begin
      @(posedge clk); seek <= m[0];
      repeat (4) @(posedge clk);
      #1 check("drive pins", {seek_mode, lcd, frs, head_select, double_density,
                              vco_enable, 2'b00}, {m[0], m[0], ~m[0], {3{m[0]}}, 2'b00});
      check("sensed", {wprot, dfault, twos, trk0, 4'h0},
            {~m[0], ~m[0], m[0], m[0], 4'h0});
    end
    final_report();
  end
endmodule : test_fhp_host_port
